/* common/dsc_params.svh */
// Constants for the DDR device command block
`ifndef DSC_PARAMS_SVH
`define DSC_PARAMS_SVH
// Pin widths
`define DSC_ADDR_W            13
`define DSC_DQ_W              16
`define DSC_BYTE_W            8
// Command codes on {row, column, write} strobes, active low
`define DSC_CODE_MRS          3'h0
`define DSC_CODE_REF          3'h1
`define DSC_CODE_PRE          3'h2
`define DSC_CODE_ACT          3'h3
`define DSC_CODE_WRITE        3'h4
`define DSC_CODE_READ         3'h5
// Address and bank select bit roles, default burst length
`define DSC_PRECHARGE_ALL_BIT 10
`define DSC_DLL_RESET_BIT     8
`define DSC_EXT_SEL_BIT       0
`define DSC_BL_MSB            2
`define DSC_BL_DEFAULT        4'h2
// Storage shape and loop lock time in link clock cycles
`define DSC_COL_W             4
`define DSC_ROW_W             2
`define DSC_DLL_LOCK_CYCLES   8'hC8
// Register map and reset values
`define DSC_ADR_CTRL          4'h0
`define DSC_ADR_STATUS        4'h4
`define DSC_ADR_MODE          4'h8
`define DSC_ADR_EXT_MODE      4'hC
`define DSC_CTRL_SELF_REF_BIT 0
`define DSC_CTRL_RST          1'b0
`define DSC_MODE_RST          13'h0000
`endif

/* common/dsc_pkg.sv */
// Types shared by the DDR device command block
`include "dsc_params.svh"
package dsc_pkg;
  typedef struct packed {
    logic                     clkEnable;
    logic                     chipSelectN;
    logic                     rowStrobeN;
    logic                     columnStrobeN;
    logic                     writeEnableN;
    logic [1:0]               bankSelect;
    logic [`DSC_ADDR_W-1:0]   addr;
  } dsc_cmd_pins_t;

  typedef struct packed {
    logic [`DSC_DQ_W-1:0]     dq;
    logic                     lowerDataStrobe;
    logic                     upperDataStrobe;
    logic                     lowerWriteMask;
    logic                     upperWriteMask;
  } dsc_data_pins_t;

  typedef enum logic [1:0] {PWR_ACTIVE, PWR_PRE_PD, PWR_ACT_PD, PWR_SELF_REF} dsc_pwr_t;
endpackage : dsc_pkg

/* hdl/dsc_ddr_device.sv */
// DDR SDRAM device: command decode, bank and mode state, power-down, data path
//
// Summary of operation
// - Inputs are taken at the true clock rise, complement clock low.
// - Read data changes on both link clock edges, two words per period.
// - Clock enable high runs bursts and drivers; low stops them.
// - Enable drop: idle banks give precharge power-down or self refresh, else active.
// - Enable is edge-sampled, but output drivers turn off at once.
// - While powered down or refreshing, all inputs but clocks and enable ignored.
// - Commands decode only with chip select registered low.
// - Command is the strobe pattern with chip select at one edge.
// - Write words with their mask high are discarded.
// - Lower mask and strobe own DQ0-DQ7; upper ones own DQ8-DQ15.
// - Bank select picks the bank of activate, read, write, precharge.
// - Activate takes the row; read and write take column and auto-precharge.
// - Precharge with bit 10 high closes all banks, else the selected one.
// - Mode register write loads address into base or extended register.
// - Device drives strobe edge-aligned on reads; controller centres it on writes.
// - Deselect ignores inputs; no-operation lets current work finish.
//
// Added by the designer: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "dsc_params.svh"
module dsc_ddr_device
#(
  parameter int         COL_W           = `DSC_COL_W,
  parameter int         ROW_W           = `DSC_ROW_W,
  parameter logic [7:0] DLL_LOCK_CYCLES = `DSC_DLL_LOCK_CYCLES
)
(
  // System
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Wishbone slave
  input  wire logic                     cyc_i,
  input  wire logic                     stb_i,
  input  wire logic                     we_i,
  input  wire logic [3:0]               adr_i,
  input  wire logic [31:0]              dat_i,
  input  wire logic [3:0]               sel_i,
  output logic      [31:0]              dat_o,
  output logic                          ack_o,
  // Memory link inputs
  input  wire logic                     linkClk,
  input  wire logic                     linkClkN,
  input  wire dsc_pkg::dsc_cmd_pins_t   cmdPins,
  input  wire dsc_pkg::dsc_data_pins_t  dataPins,
  // Memory link outputs
  output logic      [`DSC_DQ_W-1:0]     dataOut,
  output logic                          dataOe,
  output logic      [1:0]               dataStrobeOut,
  output logic                          dataStrobeOe
);
  localparam int IDX_W = 2 + ROW_W + COL_W;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [1:0]               clkS1, clkS2;
  logic                     clkPrev, ldsPrev, udsPrev;
  dsc_pkg::dsc_cmd_pins_t   cmdS1, cmdS2;
  dsc_pkg::dsc_data_pins_t  datS1, datS2;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      clkS1   <= '0;
      clkS2   <= '0;
      cmdS1   <= '0;
      cmdS2   <= '0;
      datS1   <= '0;
      datS2   <= '0;
      clkPrev <= 1'b0;
      ldsPrev <= 1'b0;
      udsPrev <= 1'b0;
    end
    else
    begin
      clkS1   <= {linkClk, linkClkN};
      clkS2   <= clkS1;
      cmdS1   <= cmdPins;
      cmdS2   <= cmdS1;
      datS1   <= dataPins;
      datS2   <= datS1;
      clkPrev <= clkS2[1];
      ldsPrev <= datS2.lowerDataStrobe;
      udsPrev <= datS2.upperDataStrobe;
    end
  end

  // ----------------------------------------
  // Edge detection and command decode
  // ----------------------------------------
  dsc_pkg::dsc_pwr_t        pwr, next_pwr;
  logic                     ckeReg, selfRefOnIdle;
  logic [3:0]               bankOpen;
  logic [ROW_W-1:0]         openRow [4];
  logic [`DSC_ADDR_W-1:0]   modeReg, extModeReg;
  logic [7:0]               dllCnt, refCnt;

  wire linkRise = clkS2[1] && !clkPrev && !clkS2[0];
  wire linkFall = !clkS2[1] && clkPrev;
  wire linkEdge = linkRise || linkFall;
  // Only a synchronised enable is visible here; drivers still drop without a link edge
  wire run      = cmdS2.clkEnable;
  wire awake    = pwr == dsc_pkg::PWR_ACTIVE;
  wire [2:0] code = {cmdS2.rowStrobeN, cmdS2.columnStrobeN, cmdS2.writeEnableN};
  wire take     = linkRise && awake && ckeReg && !cmdS2.chipSelectN;
  wire isAct    = take && code == `DSC_CODE_ACT;
  wire isRead   = take && code == `DSC_CODE_READ;
  wire isWrite  = take && code == `DSC_CODE_WRITE;
  wire isPre    = take && code == `DSC_CODE_PRE;
  wire isRef    = take && code == `DSC_CODE_REF;
  wire isMrs    = take && code == `DSC_CODE_MRS;
  wire [1:0] ba = cmdS2.bankSelect;
  wire [`DSC_ADDR_W-1:0] addr = cmdS2.addr;
  wire preAll   = addr[`DSC_PRECHARGE_ALL_BIT];
  wire extSel   = ba[`DSC_EXT_SEL_BIT];
  wire selfRefCmd = !cmdS2.chipSelectN && code == `DSC_CODE_REF;
  wire enableDrop = awake && linkRise && ckeReg && !cmdS2.clkEnable;

  // ----------------------------------------
  // Power state
  // ----------------------------------------
  always_comb
  begin
    next_pwr = pwr;
    case (pwr)
      dsc_pkg::PWR_ACTIVE:
        if (enableDrop)
          next_pwr = (bankOpen != 4'h0) ? dsc_pkg::PWR_ACT_PD :
                     (selfRefOnIdle || selfRefCmd) ? dsc_pkg::PWR_SELF_REF :
                     dsc_pkg::PWR_PRE_PD;
      default:
        if (linkRise && cmdS2.clkEnable)
          next_pwr = dsc_pkg::PWR_ACTIVE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pwr    <= dsc_pkg::PWR_ACTIVE;
      ckeReg <= 1'b0;
    end
    else
    begin
      pwr <= next_pwr;
      if (linkRise)
        ckeReg <= cmdS2.clkEnable;
    end
  end

  // ----------------------------------------
  // Burst engine wires
  // ----------------------------------------
  logic                     burstRd, burstWr, rdDrive, strobeOut, bAp;
  logic [3:0]               bCnt, upCnt;
  logic [1:0]               bBank;
  logic [ROW_W-1:0]         bRow;
  logic [COL_W-1:0]         bCol;
  logic [`DSC_DQ_W-1:0]     mem [2**IDX_W];

  wire [2:0] blCode   = modeReg[`DSC_BL_MSB:0];
  wire [3:0] burstLen = (blCode >= 3'h1 && blCode <= 3'h3) ? (4'h1 << blCode) : `DSC_BL_DEFAULT;
  wire loEdge   = datS2.lowerDataStrobe != ldsPrev;
  wire upEdge   = datS2.upperDataStrobe != udsPrev;
  wire loWrEdge = burstWr && run && loEdge && bCnt != burstLen;
  wire upWrEdge = burstWr && run && upEdge && upCnt != burstLen;
  wire loWr     = loWrEdge && !datS2.lowerWriteMask;
  wire upWr     = upWrEdge && !datS2.upperWriteMask;
  wire [IDX_W-1:0] loIdx = {bBank, bRow, bCol + COL_W'(bCnt)};
  wire [IDX_W-1:0] upIdx = {bBank, bRow, bCol + COL_W'(upCnt)};
  wire rdDone   = burstRd && linkEdge && bCnt == burstLen;
  wire wrDone   = burstWr && bCnt == burstLen && upCnt == burstLen;
  wire burstDone = run && (rdDone || wrDone);
  wire apClose  = burstDone && bAp;

  // ----------------------------------------
  // Bank, mode and refresh state
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      bankOpen <= 4'h0;
    else if (isPre && preAll)
      bankOpen <= 4'h0;
    else if (isPre)
      bankOpen[ba] <= 1'b0;
    else if (isAct)
      bankOpen[ba] <= 1'b1;
    else if (apClose)
      bankOpen[bBank] <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (isAct)
      openRow[ba] <= addr[ROW_W-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      modeReg    <= `DSC_MODE_RST;
      extModeReg <= `DSC_MODE_RST;
      dllCnt     <= 8'h00;
      refCnt     <= 8'h00;
    end
    else
    begin
      if (isMrs && !extSel)
        modeReg <= addr;
      if (isMrs && extSel)
        extModeReg <= addr;
      if (isMrs && !extSel && addr[`DSC_DLL_RESET_BIT])
        dllCnt <= DLL_LOCK_CYCLES;
      else if (linkRise && dllCnt != 8'h00)
        dllCnt <= dllCnt - 8'h01;
      if (isRef)
        refCnt <= refCnt + 8'h01;
    end
  end

  // ----------------------------------------
  // Burst engine
  // ----------------------------------------
  // A new read or write restarts the engine; the old burst is cut short
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      burstRd   <= 1'b0;
      burstWr   <= 1'b0;
      rdDrive   <= 1'b0;
      strobeOut <= 1'b0;
      dataOut   <= '0;
      bCnt      <= 4'h0;
      upCnt     <= 4'h0;
      bAp       <= 1'b0;
      bBank     <= 2'h0;
      bRow      <= '0;
      bCol      <= '0;
    end
    else if (isRead || isWrite)
    begin
      burstRd <= isRead;
      burstWr <= isWrite;
      bCnt    <= 4'h0;
      upCnt   <= 4'h0;
      bBank   <= ba;
      bRow    <= openRow[ba];
      bCol    <= addr[COL_W-1:0];
      bAp     <= preAll;
    end
    else if (burstDone)
    begin
      burstRd   <= 1'b0;
      burstWr   <= 1'b0;
      rdDrive   <= 1'b0;
      strobeOut <= 1'b0;
    end
    else if (burstRd && linkEdge && run)
    begin
      dataOut   <= mem[loIdx];
      strobeOut <= ~bCnt[0];
      rdDrive   <= 1'b1;
      bCnt      <= bCnt + 4'h1;
    end
    else
    begin
      if (loWrEdge)
        bCnt <= bCnt + 4'h1;
      if (upWrEdge)
        upCnt <= upCnt + 4'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (loWr)
      mem[loIdx][`DSC_BYTE_W-1:0] <= datS2.dq[`DSC_BYTE_W-1:0];
    if (upWr)
      mem[upIdx][`DSC_DQ_W-1:`DSC_BYTE_W] <= datS2.dq[`DSC_DQ_W-1:`DSC_BYTE_W];
  end

  // Drivers fall with the synchronised enable in cmdS2, not at the next link edge
  assign dataOe        = rdDrive && cmdS2.clkEnable;
  assign dataStrobeOe  = rdDrive && cmdS2.clkEnable;
  assign dataStrobeOut = {2{strobeOut}};

  // ----------------------------------------
  // Wishbone registers
  // ----------------------------------------
  wire wbReq   = cyc_i && stb_i && !ack_o;
  wire selCtrl = adr_i == `DSC_ADR_CTRL;
  wire selStat = adr_i == `DSC_ADR_STATUS;
  wire selMode = adr_i == `DSC_ADR_MODE;
  wire selExt  = adr_i == `DSC_ADR_EXT_MODE;
  // The write lands on the edge where the master sees ack, not one edge earlier
  wire wbWrite = cyc_i && stb_i && ack_o && we_i && selCtrl && sel_i[0];
  wire [31:0] statusWord = {16'h0000, refCnt, bankOpen, burstRd || burstWr,
                            dllCnt != 8'h00, pwr};
  wire [31:0] rdMux = selCtrl ? {31'h0, selfRefOnIdle} :
                      selStat ? statusWord :
                      selMode ? {19'h0, modeReg} :
                      selExt  ? {19'h0, extModeReg} : 32'h0;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ack_o         <= 1'b0;
      dat_o         <= 32'h0;
      selfRefOnIdle <= `DSC_CTRL_RST;
    end
    else
    begin
      ack_o <= wbReq;
      if (wbReq)
        dat_o <= rdMux;
      if (wbWrite)
        selfRefOnIdle <= dat_i[`DSC_CTRL_SELF_REF_BIT];
    end
  end

  // ----------------------------------------
  // Assertions and cover points
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  desel_ignore_a: assert property (
    linkRise && cmdS2.chipSelectN && !apClose |=> $stable(bankOpen) && $stable(modeReg))
    else $error("deselected edge changed state");
  act_open_a: assert property (
    isAct |=> bankOpen[$past(ba)] && openRow[$past(ba)] == $past(addr[ROW_W-1:0]))
    else $error("activate did not open bank");
  pre_all_a: assert property (
    isPre && preAll |=> bankOpen == 4'h0)
    else $error("precharge all left bank open");
  pre_one_a: assert property (
    isPre && !preAll |=> !bankOpen[$past(ba)] && (bankOpen | (4'h1 << $past(ba))) ==
      ($past(bankOpen) | (4'h1 << $past(ba))))
    else $error("single precharge touched wrong bank");
  mrs_load_a: assert property (
    isMrs |=> ($past(extSel) ? extModeReg : modeReg) == $past(addr))
    else $error("mode register not loaded");
  pd_enter_a: assert property (
    enableDrop && bankOpen != 4'h0 |=> pwr == dsc_pkg::PWR_ACT_PD)
    else $error("active power-down not entered");
  oe_async_a: assert property (
    !cmdS1.clkEnable |=> !dataOe && !dataStrobeOe)
    else $error("driver on with enable low");
  sleep_mute_a: assert property (
    !awake && linkRise && !apClose |=> $stable(bankOpen) && $stable(modeReg) && $stable(refCnt))
    else $error("command taken while asleep");
  read_ddr_a: assert property (
    burstRd && linkEdge && run && bCnt != burstLen && !isRead && !isWrite
      |=> strobeOut == ~$past(bCnt[0]) && rdDrive)
    else $error("read word not driven on link edge");

  mrs_seen_c:   cover property (isMrs && !extSel && addr[`DSC_DLL_RESET_BIT]);
  self_ref_c:   cover property (pwr == dsc_pkg::PWR_SELF_REF);
  read_done_c:  cover property (burstRd && burstDone);
  write_mask_c: cover property (loWrEdge && datS2.lowerWriteMask);
endmodule : dsc_ddr_device

/* tb/dsc_ctrl_model.sv */
// Memory controller model driving the link side of the DDR device
`timescale 1ns/1ps
`include "dsc_params.svh"
module dsc_ctrl_model
#(
  parameter int INIT_WAIT_NS = 200000
)
(
  // Link clock pair
  output logic                    linkClk,
  output logic                    linkClkN,
  // Command, address and data pins
  output dsc_pkg::dsc_cmd_pins_t  cmdPins,
  output dsc_pkg::dsc_data_pins_t dataPins
);
  localparam logic [2:0] NOP = 3'h7;
  assign linkClkN = ~linkClk;
  // ------------------------------------------------
  // Clock runs free from power-up, enable held low
  // ------------------------------------------------
  initial
  begin
    cmdPins = {1'b0, 1'b0, NOP, 15'h0000};
    dataPins = '0;
    linkClk = 1'b0;
    #3;
    forever #80 linkClk = ~linkClk;
  end
  // ------------------------------------------------
  // cke and cmd change pins at the link fall, clear of the rise; ckeNow changes enable at once
  // ------------------------------------------------
  task automatic ckeNow(input logic v);
    cmdPins.clkEnable <= v;
  endtask : ckeNow
  task automatic cke(input logic v);
    @(negedge linkClk);
    ckeNow(v);
  endtask : cke
  task automatic cmd(input logic [2:0] c, input logic [1:0] ba, input logic [12:0] a,
                     input logic csN);
    @(negedge linkClk);
    cmdPins[18:0] <= {csN, c, ba, a};
    @(negedge linkClk);
    // A whole idle cycle follows, which also covers the mode write settle time
    cmdPins[18:0] <= {1'b0, NOP, ~ba, ~a};
  endtask : cmd
  task automatic wr(input logic [1:0] ba, input logic [63:0] w, input logic [3:0] lm, um);
    cmd(`DSC_CODE_WRITE, ba, 13'h0000, 1'b0);
    for (int k = 0; k < 4; k++)
    begin
      dataPins <= {w[16*k +: 16], dataPins.lowerDataStrobe, dataPins.upperDataStrobe,
                   lm[k], um[k]};
      #20;
      // Strobe sits mid-window so the synchronised data is settled around it
      dataPins.lowerDataStrobe <= ~dataPins.lowerDataStrobe;
      dataPins.upperDataStrobe <= ~dataPins.upperDataStrobe;
      #20;
    end
    dataPins <= {~w[63:48], 4'h0};
  endtask : wr
  task automatic init(input int lockCycles, input logic [12:0] opMode);
    #(INIT_WAIT_NS);
    cke(1'b1);
    cmd(`DSC_CODE_PRE, 2'h0, 13'h0400, 1'b0);
    cmd(`DSC_CODE_MRS, 2'h1, 13'h0000, 1'b0);
    cmd(`DSC_CODE_MRS, 2'h0, 13'h0100, 1'b0);
    cmd(`DSC_CODE_PRE, 2'h0, 13'h0400, 1'b0);
    repeat (lockCycles) @(posedge linkClk);
    repeat (2) cmd(`DSC_CODE_REF, 2'h0, 13'h0000, 1'b0);
    cmd(`DSC_CODE_MRS, 2'h0, opMode & 13'h1EFF, 1'b0);
  endtask : init
endmodule : dsc_ctrl_model

/* tb/tb.sv */
// Self-checking bench for the DDR device command block
`timescale 1ns/1ps
`include "dsc_params.svh"
module tb;
  localparam int LOCK = 8;
  logic                    clk, rst_n, cyc_i, stb_i, we_i, ack_o;
  logic [3:0]              adr_i, sel_i;
  logic [31:0]             dat_i, dat_o;
  logic                    linkClk, linkClkN, dataOe, dataStrobeOe, prevOe, prevStb;
  logic [15:0]             dataOut;
  logic [1:0]              dataStrobeOut;
  logic [63:0]             w1, w2;
  dsc_pkg::dsc_cmd_pins_t  cmdPins;
  dsc_pkg::dsc_data_pins_t dataPins;
  logic [31:0]             expWb[$];
  logic [15:0]             expDq[$];
  int                      n_mismatch, n_compared;
  integer                  seed = 32'hC5DE8333;

  dsc_ddr_device #(.DLL_LOCK_CYCLES(8'(LOCK))) i_dsc_ddr_device
  (
    .clk, .rst_n, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .sel_i, .dat_o, .ack_o,
    .linkClk, .linkClkN, .cmdPins, .dataPins,
    .dataOut, .dataOe, .dataStrobeOut, .dataStrobeOe
  );
  dsc_ctrl_model i_dsc_ctrl_model (.linkClk, .linkClkN, .cmdPins, .dataPins);

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ------------------------------------------------
  // Shared tasks
  // ------------------------------------------------
  task automatic check(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge clk);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, s};
    do @(posedge clk); while (ack_o !== 1'b1);
    {cyc_i, stb_i} <= 2'b00;
  endtask : wb
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    expWb.push_back(e);
    wb(1'b0, a, 32'($random(seed)), 4'($random(seed)));
  endtask : rd
  task automatic cmd(input logic [2:0] c, input logic [1:0] ba, input logic [12:0] a);
    i_dsc_ctrl_model.cmd(c, ba, a, 1'b0);
  endtask : cmd
  task automatic lk(input int n);
    repeat (n) @(posedge linkClk);
  endtask : lk
  function automatic logic [31:0] st(input logic [1:0] p, input logic [3:0] b);
    return {16'h0000, 8'h02, b, 2'b00, p};
  endfunction : st
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  // ------------------------------------------------
  // Output watcher: a strobe flip marks a new read word
  // ------------------------------------------------
  always @(posedge clk)
  begin
    if (ack_o === 1'b1 && we_i === 1'b0)
      check(dat_o, expWb.size() > 0 ? expWb.pop_front() : ~dat_o);
    if (dataOe === 1'b1 && (prevOe !== 1'b1 || dataStrobeOut[0] !== prevStb))
    begin
      check({16'h0, dataOut}, {16'h0, expDq.size() > 0 ? expDq.pop_front() : ~dataOut});
      // A new word shows on both strobe lanes, high first in a burst
      check({31'h0, dataStrobeOe}, 32'h1);
      check({30'h0, dataStrobeOut}, {30'h0, {2{!(prevOe && prevStb)}}});
    end
    prevOe <= dataOe;
    prevStb <= dataStrobeOut[0];
  end
  initial
  begin
    #600000;
    n_mismatch++;
    report_and_stop();
  end
  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} = '0;
    {n_mismatch, n_compared, prevOe, prevStb} = '0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 4; i < 16; i += 2) wb(1'b1, 4'(i), 32'($random(seed)) | 32'h1, 4'($random(seed)));
    for (int i = 0; i < 16; i++) rd(4'(i), 32'h0);
    $display("test reset done");
    i_dsc_ctrl_model.init(LOCK + 2, 13'h0002);
    rd(`DSC_ADR_STATUS, st(2'h0, 4'h0));
    rd(`DSC_ADR_MODE, 32'h2);
    cmd(`DSC_CODE_MRS, 2'h1, 13'h0001);
    rd(`DSC_ADR_EXT_MODE, 32'h1);
    rd(`DSC_ADR_MODE, 32'h2);
    cmd(`DSC_CODE_MRS, 2'h1, 13'h0000);
    $display("test init done");
    i_dsc_ctrl_model.cmd(`DSC_CODE_ACT, 2'h3, 13'($random(seed)), 1'b1);
    rd(`DSC_ADR_STATUS, st(2'h0, 4'h0));
    cmd(`DSC_CODE_ACT, 2'h2, 13'($random(seed)));
    cmd(`DSC_CODE_ACT, 2'h1, 13'($random(seed)));
    rd(`DSC_ADR_STATUS, st(2'h0, 4'h6));
    cmd(`DSC_CODE_PRE, 2'h2, 13'($random(seed)) & 13'h1BFF);
    rd(`DSC_ADR_STATUS, st(2'h0, 4'h2));
    cmd(`DSC_CODE_PRE, 2'h0, 13'($random(seed)) | 13'h0400);
    rd(`DSC_ADR_STATUS, st(2'h0, 4'h0));
    $display("test banks done");
    w1 = {$random(seed), $random(seed)};
    w2 = {$random(seed), $random(seed)};
    cmd(`DSC_CODE_ACT, 2'h0, 13'h0000);
    i_dsc_ctrl_model.wr(2'h0, w1, 4'h0, 4'h0);
    i_dsc_ctrl_model.wr(2'h0, w2, 4'h2, 4'h4);
    expDq.push_back(w2[15:0]);
    expDq.push_back({w2[31:24], w1[23:16]});
    expDq.push_back({w1[47:40], w2[39:32]});
    expDq.push_back(w2[63:48]);
    cmd(`DSC_CODE_READ, 2'h0, 13'h0400);
    lk(6);
    check(32'(expDq.size()), 32'h0);
    rd(`DSC_ADR_STATUS, st(2'h0, 4'h0));
    $display("test data done");
    cmd(`DSC_CODE_ACT, 2'h3, 13'h0000);
    i_dsc_ctrl_model.cke(1'b0);
    lk(2);
    rd(`DSC_ADR_STATUS, st(2'h2, 4'h8));
    cmd(`DSC_CODE_PRE, 2'h0, 13'h0400);
    i_dsc_ctrl_model.cke(1'b1);
    lk(2);
    rd(`DSC_ADR_STATUS, st(2'h0, 4'h8));
    cmd(`DSC_CODE_PRE, 2'h3, 13'h0000);
    i_dsc_ctrl_model.cke(1'b0);
    lk(2);
    rd(`DSC_ADR_STATUS, st(2'h1, 4'h0));
    i_dsc_ctrl_model.cke(1'b1);
    wb(1'b1, `DSC_ADR_CTRL, 32'h1, 4'hF);
    wb(1'b1, `DSC_ADR_CTRL, 32'h0, 4'hE);
    rd(`DSC_ADR_CTRL, 32'h1);
    i_dsc_ctrl_model.cke(1'b0);
    lk(2);
    rd(`DSC_ADR_STATUS, st(2'h3, 4'h0));
    i_dsc_ctrl_model.cke(1'b1);
    wb(1'b1, `DSC_ADR_CTRL, 32'h0, 4'hF);
    $display("test power done");
    cmd(`DSC_CODE_ACT, 2'h0, 13'h0000);
    expDq.push_back(w2[15:0]);
    cmd(`DSC_CODE_READ, 2'h0, 13'h0000);
    for (int k = 0; k < 20 && dataOe !== 1'b1; k++) @(posedge clk);
    i_dsc_ctrl_model.ckeNow(1'b0);
    repeat (4) @(posedge clk);
    check({30'h0, dataOe, dataStrobeOe}, 32'h0);
    $display("test output stop done");
    report_and_stop();
  end
endmodule : tb
